/* File: src/bpc_map.vh */
// register map, field positions, reset values and timing counts of the lane BER checker
`ifndef BPC_MAP_VH
`define BPC_MAP_VH

// register indices as printed; byte address is four times the index
`define BPC_IDX_CLK_ENABLE      10'h315
`define BPC_IDX_TEST_CONTROL    10'h316
`define BPC_IDX_THRESH_LOW      10'h317
`define BPC_IDX_THRESH_MID      10'h318
`define BPC_IDX_THRESH_HIGH     10'h319
`define BPC_IDX_COUNT_LOW       10'h31a
`define BPC_IDX_COUNT_MID       10'h31b
`define BPC_IDX_COUNT_HIGH      10'h31c
`define BPC_IDX_PASS_STATUS     10'h31d
`define BPC_IDX_SNAP_CONTROL    10'h31e
`define BPC_IDX_SNAP_DATA       10'h31f

// test control fields
`define BPC_CTL_CLEAR_BIT       0
`define BPC_CTL_RUN_BIT         1
`define BPC_CTL_PAT_LSB         2
`define BPC_CTL_PAT_MSB         3
`define BPC_CTL_LANE_LSB        4
`define BPC_CTL_LANE_MSB        6

// snapshot control fields
`define BPC_SNP_TRIG_BIT        0
`define BPC_SNP_LANE_LSB        2
`define BPC_SNP_LANE_MSB        4

// pattern codes
`define BPC_PAT_PRBS7           2'h0
`define BPC_PAT_PRBS15          2'h1
`define BPC_PAT_PRBS31          2'h2
`define BPC_PAT_UNUSED          2'h3

// predictor taps into the received-bit history, bit 0 newest
`define BPC_TAP7_A              6
`define BPC_TAP7_B              5
`define BPC_TAP15_A             14
`define BPC_TAP15_B             13
`define BPC_TAP31_A             30
`define BPC_TAP31_B             27

// bits to gather before checking starts, one per polynomial length
`define BPC_LOCK_PRBS7          5'h07
`define BPC_LOCK_PRBS15         5'h0f
`define BPC_LOCK_PRBS31         5'h1f

// reset values and the error count ceiling
`define BPC_RST_BYTE            8'h00
`define BPC_RST_PASS            8'hff
`define BPC_RST_THRESH          24'h000000
`define BPC_COUNT_MAX           24'hffffff

`endif

/* File: src/bpc_lane_check.v */
// one lane: self-synchronising prbs predictor and saturating 24-bit error counter
`timescale 1ns/10ps
`include "bpc_map.vh"

module bpc_lane_check (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clear,
    // receive side
    input  wire        rx_bit,
    input  wire        rx_valid,
    // control
    input  wire [1:0]  pattern,
    input  wire        check_en,
    // results
    output wire [23:0] err_count,
    output wire [7:0]  recent_bits
);

    reg  [30:0] hist_reg;
    reg  [23:0] count_reg;
    reg         predict;

    // predicted bit from the two taps of the chosen polynomial
    always @* begin
        case (pattern)
            `BPC_PAT_PRBS7:  predict = hist_reg[`BPC_TAP7_A] ^ hist_reg[`BPC_TAP7_B];
            `BPC_PAT_PRBS15: predict = hist_reg[`BPC_TAP15_A] ^ hist_reg[`BPC_TAP15_B];
            `BPC_PAT_PRBS31: predict = hist_reg[`BPC_TAP31_A] ^ hist_reg[`BPC_TAP31_B];
            default:         predict = rx_bit;
        endcase
    end

    // history keeps shifting so the predictor stays locked across stops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_reg <= 31'h00000000;
        end else if (rx_valid) begin
            hist_reg <= {hist_reg[29:0], rx_bit};
        end
    end

    // saturate rather than wrap, a wrapped count would fake a pass
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `BPC_RST_THRESH;
        end else if (clear) begin
            count_reg <= `BPC_RST_THRESH; // RL4
        end else if (check_en && rx_valid && (predict != rx_bit) &&
                     (count_reg != `BPC_COUNT_MAX)) begin
            count_reg <= count_reg + 24'h000001;
        end
    end

    assign err_count   = count_reg;
    assign recent_bits = hist_reg[7:0];

endmodule // bpc_lane_check

/* File: src/bpc_ber_checker.v */
// eight-lane prbs bit error rate checker with its apb register file
`timescale 1ns/10ps
`include "bpc_map.vh"

// What this block does
// [RL1] count lane select codes 110 and 111 show lanes 6 and 7 counts
// [RL2] pattern select bits 3:2 pick prbs7, prbs15 or prbs31; code 11 checks nothing
// [RL3] test run bit 1 starts checking and counting; 0 keeps test stopped; resets 0
// [RL4] test clear held 1 resets checker state machine and all lane counters
// [RL5] 24-bit threshold over three read/write byte registers decides lane flags
// [RL6] selected lane count readable as three read-only bytes, reset zero
// [RL7] read-only eight-bit pass vector, bit n is lane n verdict
// [RL8] pass vector reads all ones after reset
// [RL9] capture lane select bits 4:2, reset zero, picks snapshot lane
// [RL10] lane fails when count exceeds threshold, passes again only after checker reset
// [RL11] checker idles until enable register is nonzero, runs while it is set
// [RL12] count lane select bits 6:4, code 000 is lane 0, ascending
// [RL13] capture trigger rising edge stores selected lane receive word into snapshot
// [RL14] far end sends the selected polynomial on every lane throughout the test
module bpc_ber_checker (
    // apb clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // receive lanes, one bit per lane per clock
    input  wire [7:0]  rx_lane_bits,
    input  wire        rx_bits_valid
);

    // checker states, one-hot
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_LOCK  = 3'h2;
    localparam [2:0] ST_CHECK = 3'h4;

    // software state
    reg  [7:0]  clk_enable_reg;
    reg         test_clear_reg;
    reg         test_run_reg;
    reg  [1:0]  pattern_select_reg;
    reg  [2:0]  count_lane_select_reg;
    reg  [23:0] threshold_reg;
    reg  [2:0]  capture_lane_select_reg;
    reg         capture_trigger_reg;
    reg         capture_trigger_prev_reg;
    reg  [7:0]  snapshot_reg;

    // checker state
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [4:0]  lock_count_reg;
    reg  [4:0]  lock_target;
    reg  [7:0]  lane_pass_flags_reg;
    reg  [1:0]  pattern_prev_reg;

    // bus decode
    wire        access;
    wire        wr_take;
    wire        wr_hit;
    wire        capture_edge;
    wire [9:0]  reg_index;
    wire        addr_aligned;
    reg         addr_hit;
    reg  [7:0]  rd_byte;

    // lane results
    wire [191:0] lane_counts;
    wire [63:0]  lane_recent;
    reg  [23:0]  sel_count;
    reg  [7:0]   snap_source;
    wire [7:0]   lane_over;
    wire         checker_on;
    wire         check_en;
    wire         pattern_changed;

    // a whole lane count is 24 bits, selected by index
    always @* begin
        case (count_lane_select_reg)
            3'h0:    sel_count = lane_counts[23:0]; // RL12
            3'h1:    sel_count = lane_counts[47:24]; // RL12
            3'h2:    sel_count = lane_counts[71:48];
            3'h3:    sel_count = lane_counts[95:72];
            3'h4:    sel_count = lane_counts[119:96];
            3'h5:    sel_count = lane_counts[143:120];
            3'h6:    sel_count = lane_counts[167:144]; // RL1
            3'h7:    sel_count = lane_counts[191:168]; // RL1
            default: sel_count = lane_counts[23:0];
        endcase
    end

    // snapshot source lane
    always @* begin
        case (capture_lane_select_reg)
            3'h0:    snap_source = lane_recent[7:0]; // RL9
            3'h1:    snap_source = lane_recent[15:8];
            3'h2:    snap_source = lane_recent[23:16];
            3'h3:    snap_source = lane_recent[31:24];
            3'h4:    snap_source = lane_recent[39:32];
            3'h5:    snap_source = lane_recent[47:40];
            3'h6:    snap_source = lane_recent[55:48];
            3'h7:    snap_source = lane_recent[63:56]; // RL9
            default: snap_source = lane_recent[7:0];
        endcase
    end

    // enable gates the checker state machine and counting; unused pattern code never runs
    assign checker_on = (clk_enable_reg != `BPC_RST_BYTE) &&
                        (pattern_select_reg != `BPC_PAT_UNUSED); // RL11 RL2
    assign check_en   = (state_reg == ST_CHECK) && !pattern_changed;

    // a pattern written while running re-primes the predictors
    assign pattern_changed = (pattern_select_reg != pattern_prev_reg);

    // apb access phase; one wait state so reads come from flops
    assign access       = psel & penable;
    assign wr_take      = access & pready & pwrite;
    assign wr_hit       = wr_take & addr_aligned;
    assign reg_index    = paddr[11:2];
    assign addr_aligned = (paddr[1:0] == 2'h0);

    // per-lane checkers
    genvar ln;
    generate
        for (ln = 0; ln < 8; ln = ln + 1) begin : g_lane
            bpc_lane_check u_lane (
                .pclk        (pclk),
                .presetn     (presetn),
                .clear       (test_clear_reg),
                .rx_bit      (rx_lane_bits[ln]),
                .rx_valid    (rx_bits_valid),
                .pattern     (pattern_select_reg),
                .check_en    (check_en),
                .err_count   (lane_counts[ln*24 +: 24]),
                .recent_bits (lane_recent[ln*8 +: 8])
            );
        end
    endgenerate

    // bits to gather before prediction is valid
    always @* begin
        case (pattern_select_reg)
            `BPC_PAT_PRBS7:  lock_target = `BPC_LOCK_PRBS7;
            `BPC_PAT_PRBS15: lock_target = `BPC_LOCK_PRBS15;
            `BPC_PAT_PRBS31: lock_target = `BPC_LOCK_PRBS31;
            default:         lock_target = `BPC_LOCK_PRBS31;
        endcase
    end

    // checker state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (test_run_reg && checker_on) begin
                    state_next = ST_LOCK; // RL3
                end
            end
            ST_LOCK: begin
                if (!test_run_reg || !checker_on) begin
                    state_next = ST_IDLE;
                end else if (rx_bits_valid && !pattern_changed &&
                             (lock_count_reg >= lock_target - 5'h01)) begin
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!test_run_reg || !checker_on) begin
                    state_next = ST_IDLE; // RL3
                end else if (pattern_changed) begin
                    state_next = ST_LOCK;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else if (test_clear_reg) begin
            state_reg <= ST_IDLE; // RL4
        end else begin
            state_reg <= state_next;
        end
    end

    // last pattern seen by the checker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_prev_reg <= `BPC_PAT_PRBS7;
        end else begin
            pattern_prev_reg <= pattern_select_reg;
        end
    end

    // lock counter restarts on every entry so a pattern change re-primes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_count_reg <= 5'h00;
        end else if (test_clear_reg || pattern_changed || (state_reg != ST_LOCK)) begin
            lock_count_reg <= 5'h00;
        end else if (rx_bits_valid) begin
            lock_count_reg <= lock_count_reg + 5'h01;
        end
    end

    // pass flags fall sticky once a count passes the threshold
    genvar pf;
    generate
        for (pf = 0; pf < 8; pf = pf + 1) begin : g_pass
            assign lane_over[pf] = (lane_counts[pf*24 +: 24] > threshold_reg); // RL5
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lane_pass_flags_reg[pf] <= 1'b1; // RL8
                end else if (test_clear_reg) begin
                    lane_pass_flags_reg[pf] <= 1'b1; // RL10
                end else if (lane_over[pf]) begin
                    lane_pass_flags_reg[pf] <= 1'b0; // RL10 RL5 RL7
                end
            end
        end
    endgenerate

    // software writes, taken at the edge that completes the transfer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_enable_reg          <= `BPC_RST_BYTE;
            test_clear_reg          <= 1'b0;
            test_run_reg            <= 1'b0;
            pattern_select_reg      <= `BPC_PAT_PRBS7;
            count_lane_select_reg   <= 3'h0;
            threshold_reg           <= `BPC_RST_THRESH;
            capture_lane_select_reg <= 3'h0;
            capture_trigger_reg     <= 1'b0;
        end else if (wr_hit) begin
            case (reg_index)
                `BPC_IDX_CLK_ENABLE: begin
                    clk_enable_reg <= pwdata[7:0]; // RL11
                end
                `BPC_IDX_TEST_CONTROL: begin
                    test_clear_reg        <= pwdata[`BPC_CTL_CLEAR_BIT]; // RL4
                    test_run_reg          <= pwdata[`BPC_CTL_RUN_BIT]; // RL3
                    pattern_select_reg    <= pwdata[`BPC_CTL_PAT_MSB:`BPC_CTL_PAT_LSB]; // RL2
                    count_lane_select_reg <= pwdata[`BPC_CTL_LANE_MSB:`BPC_CTL_LANE_LSB];
                end
                `BPC_IDX_THRESH_LOW: begin
                    threshold_reg[7:0] <= pwdata[7:0]; // RL5
                end
                `BPC_IDX_THRESH_MID: begin
                    threshold_reg[15:8] <= pwdata[7:0]; // RL5
                end
                `BPC_IDX_THRESH_HIGH: begin
                    threshold_reg[23:16] <= pwdata[7:0]; // RL5
                end
                `BPC_IDX_SNAP_CONTROL: begin
                    capture_lane_select_reg <= pwdata[`BPC_SNP_LANE_MSB:`BPC_SNP_LANE_LSB]; // RL9
                    capture_trigger_reg     <= pwdata[`BPC_SNP_TRIG_BIT];
                end
                default: begin
                    clk_enable_reg <= clk_enable_reg;
                end
            endcase
        end
    end

    assign capture_edge = capture_trigger_reg & ~capture_trigger_prev_reg;

    // snapshot on a written 0 to 1 of the trigger, not on its level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_trigger_prev_reg <= 1'b0;
            snapshot_reg             <= `BPC_RST_BYTE;
        end else begin
            capture_trigger_prev_reg <= capture_trigger_reg;
            if (capture_edge) begin
                snapshot_reg <= snap_source; // RL13
            end
        end
    end

    // read mux; count bytes follow the live selected lane
    always @* begin
        addr_hit = addr_aligned;
        rd_byte  = `BPC_RST_BYTE;
        case (reg_index)
            `BPC_IDX_CLK_ENABLE: begin
                rd_byte = clk_enable_reg;
            end
            `BPC_IDX_TEST_CONTROL: begin
                rd_byte = {1'b0, count_lane_select_reg, pattern_select_reg,
                           test_run_reg, test_clear_reg};
            end
            `BPC_IDX_THRESH_LOW: begin
                rd_byte = threshold_reg[7:0];
            end
            `BPC_IDX_THRESH_MID: begin
                rd_byte = threshold_reg[15:8];
            end
            `BPC_IDX_THRESH_HIGH: begin
                rd_byte = threshold_reg[23:16];
            end
            `BPC_IDX_COUNT_LOW: begin
                rd_byte = sel_count[7:0]; // RL6
            end
            `BPC_IDX_COUNT_MID: begin
                rd_byte = sel_count[15:8]; // RL6
            end
            `BPC_IDX_COUNT_HIGH: begin
                rd_byte = sel_count[23:16]; // RL6
            end
            `BPC_IDX_PASS_STATUS: begin
                rd_byte = lane_pass_flags_reg; // RL7
            end
            `BPC_IDX_SNAP_CONTROL: begin
                rd_byte = {3'h0, capture_lane_select_reg, 1'b0, capture_trigger_reg};
            end
            `BPC_IDX_SNAP_DATA: begin
                rd_byte = snapshot_reg;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // apb answer: pready one cycle into the access phase, data and error with it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            pready  <= 1'b1;
            prdata  <= (addr_hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
            pslverr <= ~addr_hit;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

endmodule // bpc_ber_checker

/* File: verif/bpc_prbs_tx.sv */
// prbs source model driving one pattern on all eight receive lanes
`timescale 1ns/10ps
module bpc_prbs_tx (
    // clock and reset
    input logic        pclk,
    input logic        presetn,
    // control
    input logic [1:0]  pattern,
    input logic        valid_in,
    input logic [7:0]  flip_mask,
    // lanes
    output logic [7:0] lane_bits
);
    logic [30:0] gen_reg;
    logic        new_bit;
    always_comb begin
        case (pattern)
            2'h0: new_bit = gen_reg[6] ^ gen_reg[5];
            2'h1: new_bit = gen_reg[14] ^ gen_reg[13];
            default: new_bit = gen_reg[30] ^ gen_reg[27];
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            gen_reg <= 31'h1;
        else if (valid_in)
            gen_reg <= {gen_reg[29:0], new_bit};
    end
    // idle lanes show the inverse of the last bit so a stale sample cannot match
    assign lane_bits = valid_in ? ({8{new_bit}} ^ flip_mask) : ~{8{gen_reg[0]}};
endmodule // bpc_prbs_tx

/* File: verif/bpc_ber_checker_assertions.sv */
// apb timing and response checker of the lane ber checker
`timescale 1ns/10ps
module bpc_ber_checker_assertions (
    // clock and reset
    input logic        pclk,
    input logic        presetn,
    // apb
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // lanes
    input logic [7:0]  rx_lane_bits,
    input logic        rx_bits_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_on_time: assert property (s_setup ##1 s_access |=> pready)
        else $error("ready missing one cycle after access");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_in_access: assert property (pready |-> s_access)
        else $error("ready outside an access");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    a_rdata_byte_only: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above byte");
    a_err_misaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned not refused");
    a_err_unmapped: assert property (pready && (paddr[11:2] < 10'h315 || paddr[11:2] > 10'h31f)
        |-> pslverr) else $error("unmapped not refused");
    a_err_mapped_ok: assert property (pready && paddr[1:0] == 2'h0 && paddr[11:2] >= 10'h315
        && paddr[11:2] <= 10'h31f |-> !pslverr) else $error("mapped access refused");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // bpc_ber_checker_assertions

bind bpc_ber_checker bpc_ber_checker_assertions chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_lane_bits(rx_lane_bits),
    .rx_bits_valid(rx_bits_valid));

/* File: verif/bpc_ber_checker_tb_top.sv */
// self-checking bench of the lane ber checker with a prbs source model
`timescale 1ns/10ps
`include "bpc_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module bpc_ber_checker_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  lanes;
    logic        vld = 1'b0;
    logic [7:0]  flip = 8'h0;
    logic [1:0]  pat = 2'h0;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    logic [7:0]  rd;
    logic        er;
    logic [23:0] th;
    logic [23:0] cnt [8];
    always #25 pclk = ~pclk;
    bpc_ber_checker dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_lane_bits(lanes), .rx_bits_valid(vld));
    bpc_prbs_tx tx_u (.pclk(pclk), .presetn(presetn), .pattern(pat), .valid_in(vld),
        .flip_mask(flip), .lane_bits(lanes));
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    // one transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                       input logic [1:0] lo = 2'h0);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, lo};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // a nonzero mask forces a valid bit and flips those lanes
    task automatic tick(input logic [7:0] m);
        @(posedge pclk);
        vld <= (m != 8'h0) || ($urandom % 4 != 0);
        flip <= m;
    endtask
    // a single line error costs three predictor misses: itself and two taps
    function automatic logic [7:0] pass_exp(input int p);
        for (int l = 0; l < 8; l++)
            pass_exp[l] = (p == 3) || !(cnt[l] > th);
    endfunction
    initial begin
        int k;
        logic [7:0] m;
        k = $urandom(32'hdcfb);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 'h315; i <= 'h31f; i++) begin
            apb(1'b0, 10'(i), 8'h0);
            `CHK(rd, (i == 'h31d) ? `BPC_RST_PASS : `BPC_RST_BYTE)
            `CHK(er, 1'b0)
        end
        apb(1'b0, 10'h320, 8'h0);
        `CHK(er, 1'b1)
        apb(1'b1, `BPC_IDX_THRESH_LOW, 8'h5a, 2'h2);
        `CHK(er, 1'b1)
        apb(1'b0, `BPC_IDX_THRESH_LOW, 8'h0);
        `CHK(rd, 8'h00)
        $display("test reset_and_refusal done");
        th = 24'($urandom);
        for (int b = 0; b < 3; b++)
            apb(1'b1, 10'(`BPC_IDX_THRESH_LOW + b), th[8*b +: 8]);
        for (int b = 0; b < 3; b++) begin
            apb(1'b0, 10'(`BPC_IDX_THRESH_LOW + b), 8'h0);
            `CHK(rd, th[8*b +: 8])
        end
        apb(1'b1, `BPC_IDX_COUNT_LOW, 8'h77);
        apb(1'b1, `BPC_IDX_PASS_STATUS, 8'h00);
        apb(1'b0, `BPC_IDX_COUNT_LOW, 8'h0);
        `CHK(rd, 8'h00)
        apb(1'b0, `BPC_IDX_PASS_STATUS, 8'h0);
        `CHK(rd, 8'hff)
        $display("test register_access done");
        apb(1'b1, `BPC_IDX_TEST_CONTROL, 8'h02);
        repeat (80) tick(8'h0);
        tick(8'hff);
        repeat (80) tick(8'h0);
        apb(1'b1, `BPC_IDX_TEST_CONTROL, 8'h00);
        apb(1'b0, `BPC_IDX_COUNT_LOW, 8'h0);
        `CHK(rd, 8'h00)
        $display("test gated_checker done");
        for (int p = 0; p < 4; p++) begin
            pat <= p[1:0];
            apb(1'b1, `BPC_IDX_TEST_CONTROL, 8'h01);
            apb(1'b0, `BPC_IDX_PASS_STATUS, 8'h0);
            `CHK(rd, 8'hff)
            apb(1'b1, `BPC_IDX_TEST_CONTROL, 8'h00);
            th = 24'($urandom % 7);
            for (int b = 0; b < 3; b++)
                apb(1'b1, 10'(`BPC_IDX_THRESH_LOW + b), th[8*b +: 8]);
            apb(1'b1, `BPC_IDX_CLK_ENABLE, 8'($urandom % 255 + 1));
            apb(1'b1, `BPC_IDX_TEST_CONTROL, {4'h0, p[1:0], 2'h2});
            for (int l = 0; l < 8; l++)
                cnt[l] = 24'h0;
            repeat (4) begin
                repeat (80) tick(8'h0);
                m = 8'($urandom);
                tick(m);
                for (int l = 0; l < 8; l++)
                    if (m[l] && p != 3)
                        cnt[l] += 24'h3;
            end
            repeat (80) tick(8'h0);
            apb(1'b1, `BPC_IDX_TEST_CONTROL, {4'h0, p[1:0], 2'h0});
            // errors while stopped must leave the counts alone
            tick(8'hff);
            repeat (40) tick(8'h0);
            for (int l = 0; l < 8; l++) begin
                apb(1'b1, `BPC_IDX_TEST_CONTROL, {1'b0, l[2:0], p[1:0], 2'h0});
                for (int b = 0; b < 3; b++) begin
                    apb(1'b0, 10'(`BPC_IDX_COUNT_LOW + b), 8'h0);
                    `CHK(rd, cnt[l][8*b +: 8])
                end
            end
            apb(1'b0, `BPC_IDX_PASS_STATUS, 8'h0);
            `CHK(rd, pass_exp(p))
            // a raised threshold must not revive a failed lane
            apb(1'b1, `BPC_IDX_THRESH_HIGH, 8'hff);
            apb(1'b0, `BPC_IDX_PASS_STATUS, 8'h0);
            `CHK(rd, pass_exp(p))
            $display("test pattern %0d done", p);
        end
        m = 8'($urandom % 8);
        apb(1'b1, `BPC_IDX_SNAP_CONTROL, {3'h0, m[2:0], 2'h0});
        apb(1'b0, `BPC_IDX_SNAP_CONTROL, 8'h0);
        `CHK(rd, {3'h0, m[2:0], 2'h0})
        // only the chosen lane keeps its newest bit unflipped
        tick(8'hff ^ (8'h01 << m[2:0]));
        @(posedge pclk);
        vld <= 1'b0;
        flip <= 8'h00;
        apb(1'b1, `BPC_IDX_SNAP_CONTROL, {3'h0, m[2:0], 2'h1});
        apb(1'b0, `BPC_IDX_SNAP_DATA, 8'h0);
        `CHK(rd, tx_u.gen_reg[7:0])
        $display("test snapshot done");
        stop_test();
    end
endmodule // bpc_ber_checker_tb_top
